// ### tb/cts_host_model.sv
module cts_host_model
(
    input  wire logic core_clk,
    output logic      serial_strobe,
    output logic      serial_clock_in,
    output logic      serial_data_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle: strobe high, clock parked high, no frame in flight
    initial
    begin
        serial_strobe = 1'b1;
        serial_clock_in = 1'b1;
        serial_data_in = 1'b0;
    end
    // 40 bits lsb first under a low strobe, 4 clocks per half period
    task automatic send_frame(input logic [39:0] f);
        @(posedge core_clk);
        #2 serial_strobe = 1'b0;
        for (int i = 0; i < 40; i++)
        begin
            repeat (4) @(posedge core_clk);
            #2 serial_clock_in = 1'b0;
            serial_data_in = f[i]; // stable across the rising clock
            repeat (4) @(posedge core_clk);
            #2 serial_clock_in = 1'b1;
        end
        repeat (4) @(posedge core_clk);
        #2 serial_strobe = 1'b1;
        repeat (4) @(posedge core_clk);
        // released data line shows the inverse so a stale value cannot pass
        #2 serial_data_in = ~serial_data_in;
    endtask
    // parallel mode: the same pins as static levels
    task automatic set_pins(input logic s, input logic k, input logic d);
        repeat (4) @(posedge core_clk);
        #2 serial_strobe = s;
        serial_clock_in = k;
        serial_data_in = d;
    endtask
endmodule

// ### tb/cts_serial_control_bench.sv
`include "cts_defines.svh"

module cts_serial_control_bench
    import cts_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        input_method_select = 1'b0;
    logic        output_stop_in = 1'b1;
    logic        line_sync_in = 1'b1;
    logic        readout_pulse_a = 1'b0;
    logic [8:0]  wave = 9'h000;
    logic [15:0] rnd = 16'h8349;
    logic        serial_strobe, serial_clock_in, serial_data_in;
    logic        drive_enable, sync_gen_run, line_sync_out, vertical_sync_out;
    logic        integration_window_out, sum_ok, readout_allowed, pscan_sweep_active;
    logic [4:0]  pscan_sweeps_per_line;
    cts_state_t  op_state;
    cts_state_t  cur;
    cts_vdrive_t vdrive;
    cts_config_t config_out;
    logic [15:0] r;
    int          failures = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          i;
    logic [7:0]  sels [9] = '{8'h01, 8'h80, 8'hC1, 8'h83, 8'h81, 8'h81, 8'h81, 8'h81, 8'h81};
    logic [2:0]  cats [9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h3, 3'h4, 3'h3, 3'h2};

    cts_host_model host (.core_clk(core_clk), .serial_strobe(serial_strobe),
        .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in));
    cts_serial_control uut (.core_clk(core_clk), .rst_n(rst_n), .serial_strobe(serial_strobe),
        .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
        .input_method_select(input_method_select), .output_stop_in(output_stop_in),
        .line_sync_in(line_sync_in), .readout_pulse_a(readout_pulse_a),
        .readout_pulse_b(wave[0]), .int_line_sync(wave[1]), .int_vertical_sync(wave[2]),
        .exposure_pulse(wave[3]), .vclk_phase1(wave[4]), .vclk_phase2a(wave[5]),
        .vclk_phase2b(wave[6]), .vclk_phase3(wave[7]), .sweep_pulse(wave[8]),
        .op_state(op_state), .drive_enable(drive_enable), .sync_gen_run(sync_gen_run),
        .line_sync_out(line_sync_out), .vertical_sync_out(vertical_sync_out),
        .integration_window_out(integration_window_out), .vdrive(vdrive),
        .config_out(config_out), .sum_ok(sum_ok), .readout_allowed(readout_allowed),
        .pscan_sweep_active(pscan_sweep_active), .pscan_sweeps_per_line(pscan_sweeps_per_line));

    always #10 core_clk = ~core_clk;

    function automatic logic [15:0] xs(input logic [15:0] v);
        logic [15:0] t;
        t = v ^ (v << 7);
        t = t ^ (t >> 9);
        return t ^ (t << 8);
    endfunction
    // frame with select, category, data and a correct or corrupted sum
    function automatic logic [39:0] mk(input logic [7:0] sel, input logic [2:0] cat,
                                       input logic [20:0] d, input logic bad);
        logic [31:0] b;
        b = {d, cat, sel};
        return {8'h00 - b[7:0] - b[15:8] - b[23:16] - b[31:24] + {7'h00, bad}, b};
    endfunction
    function automatic cts_state_t exp_state(input logic [1:0] st);
        return st[1] ? CTS_STANDBY : (st[0] ? CTS_SLEEP : CTS_RUN);
    endfunction
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, want, seen);
        end
    endtask
    task automatic close_out();
        if (failures == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // read the random word at the edge, before the waveform process moves it
    task automatic draw(output logic [15:0] v);
        @(posedge core_clk);
        v = rnd;
        #2;
    endtask

    // random waveform inputs; periodic syncs so the apply points keep recurring
    always @(posedge core_clk)
    begin
        #2;
        rnd = xs(rnd);
        wave = rnd[8:0];
        cyc++;
        line_sync_in = (cyc[3:0] > 4'h1);
        readout_pulse_a = (cyc[5:0] == 6'h08);
        if (cyc == 60000)
        begin
            failures++;
            close_out();
        end
    end

    initial
    begin
        repeat (5) @(posedge core_clk);
        #2 rst_n = 1'b1;
        repeat (4) @(posedge core_clk);
        #2;
        check("state", {6'h00, op_state}, {6'h00, CTS_RUN});
        check("sum_ok", {7'h00, sum_ok}, 8'h00);
        // checking off: corrupted sums still land, sum flag still tracks them
        for (i = 0; i < 8; i++)
        begin
            draw(r);
            output_stop_in = r[2] | (i == 0);
            host.send_frame(mk(8'h81, `CTS_CAT_MODE, {12'h000, r[3], 1'b0, r[0], 6'h00}, r[1]));
            cur = exp_state({1'b0, r[0]});
            check("state", {6'h00, op_state}, {6'h00, cur});
            check("sum_ok", {7'h00, sum_ok}, {7'h00, !r[1]});
            check("drive", {7'h00, drive_enable}, {7'h00, cur == CTS_RUN && output_stop_in});
        end
        output_stop_in = 1'b1;
        host.send_frame(mk(8'h81, `CTS_CAT_MODE, 21'h00_0040, 1'b0));
        // each wrong-select or non-mode frame would move the state back to run
        for (i = 0; i < 9; i++)
        begin
            host.send_frame(mk(sels[i], cats[i], 21'h00_0000, 1'b0));
            check("state", {6'h00, op_state}, {6'h00, CTS_SLEEP});
            check("sum_ok", {7'h00, sum_ok}, 8'h01);
        end
        host.send_frame(mk(8'h81, `CTS_CAT_SYSTEM, 21'h00_0021, 1'b0));
        check("sync_run", {7'h00, sync_gen_run}, 8'h00);
        // checking bit acts at once from the stored system word
        repeat (200) @(posedge core_clk);
        host.send_frame(mk(8'h81, `CTS_CAT_MODE, 21'h00_0000, 1'b1));
        check("state", {6'h00, op_state}, {6'h00, CTS_SLEEP});
        check("sum_ok", {7'h00, sum_ok}, 8'h00);
        host.send_frame(mk(8'h81, `CTS_CAT_MODE, 21'h00_0000, 1'b0));
        check("state", {6'h00, op_state}, {6'h00, CTS_RUN});
        input_method_select = 1'b1;
        // strobe low only with clock low: 0/0/1 is a forbidden clock set
        for (i = 0; i < 8; i++)
        begin
            host.set_pins(i[0] | i[1], i[1], i[2]);
            repeat (3) @(posedge core_clk);
            #2;
            check("fast", {7'h00, config_out.fast_hclk_select}, {7'h00, i[0] | i[1]});
            check("prog", {7'h00, config_out.fast_readout_mode}, {7'h00, i[1]});
            check("slow", {3'h0, config_out.slow_shutter_count},
                  {3'h0, (i[2] ? `CTS_PRESET_LONG : `CTS_PRESET_SHORT)});
        end
        check("state", {6'h00, op_state}, {6'h00, CTS_RUN});
        host.set_pins(1'b1, 1'b1, 1'b0);
        input_method_select = 1'b0;
        host.send_frame(mk(8'h81, `CTS_CAT_MODE, 21'h00_00C0, 1'b0));
        check("state", {6'h00, op_state}, {6'h00, CTS_STANDBY});
        check("drive", {7'h00, drive_enable}, 8'h00);
        check("sync_run", {7'h00, sync_gen_run}, 8'h00);
        rst_n = 1'b0;
        repeat (2) @(posedge core_clk);
        #2 rst_n = 1'b1;
        repeat (4) @(posedge core_clk);
        #2;
        check("state", {6'h00, op_state}, {6'h00, CTS_RUN});
        host.send_frame(mk(8'h81, `CTS_CAT_MODE, 21'h00_0040, 1'b1));
        check("state", {6'h00, op_state}, {6'h00, CTS_SLEEP});
        // fast clock plus status select, then by-three divide: legal 1/1/0 set
        host.send_frame(mk(8'h81, `CTS_CAT_SYSTEM, 21'h00_00C0, 1'b0));
        host.send_frame(mk(8'h81, `CTS_CAT_MODE, 21'h00_0200, 1'b0));
        repeat (40) @(posedge core_clk);
        #2;
        check("triple", {7'h00, config_out.triple_divide_select}, 8'h01);
        check("fast", {7'h00, config_out.fast_hclk_select}, 8'h01);
        check("window", {7'h00, integration_window_out}, 8'h01);
        // checking is off, so a bad sum still lands and the window shows the failure
        host.send_frame(mk(8'h81, `CTS_CAT_MODE, 21'h00_0200, 1'b1));
        check("window", {7'h00, integration_window_out}, 8'h00);
        close_out();
    end
endmodule

bind cts_serial_control cts_serial_control_properties chk (.core_clk(core_clk), .rst_n(rst_n),
    .serial_strobe(serial_strobe), .output_stop_in(output_stop_in), .op_state(op_state),
    .drive_enable(drive_enable), .sync_gen_run(sync_gen_run), .line_sync_out(line_sync_out),
    .vertical_sync_out(vertical_sync_out), .integration_window_out(integration_window_out),
    .vdrive(vdrive), .config_out(config_out), .sum_ok(sum_ok),
    .pscan_sweeps_per_line(pscan_sweeps_per_line));

// ### tb/cts_serial_control_properties.sv
module cts_serial_control_properties
    import cts_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        serial_strobe,
    input wire logic        output_stop_in,
    input wire cts_state_t  op_state,
    input wire logic        drive_enable,
    input wire logic        sync_gen_run,
    input wire logic        line_sync_out,
    input wire logic        vertical_sync_out,
    input wire logic        integration_window_out,
    input wire cts_vdrive_t vdrive,
    input wire cts_config_t config_out,
    input wire logic        sum_ok,
    input wire logic [4:0]  pscan_sweeps_per_line
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    localparam cts_vdrive_t IDLE_DRIVE = {CTS_LVL_MID, CTS_LVL_HIGH, CTS_LVL_HIGH,
                                          CTS_LVL_MID, CTS_LVL_HIGH};
    // strobe rise at the pin, seen three clocks back after the two sync stages
    sequence strobe_rise_3ago;
        $past(serial_strobe, 3) && !$past(serial_strobe, 4);
    endsequence
    // registered outputs need one quiet cycle before they settle
    sequence quiet_two;
        !drive_enable ##1 !drive_enable;
    endsequence
    // reset checks must run while reset is low, so they carry no disable
    reset_state_a: assert property (disable iff (1'b0) !rst_n |=> op_state == CTS_RUN
        && !sum_ok && !integration_window_out && !line_sync_out && !vertical_sync_out)
        else $error("outputs not cleared by reset");
    reset_drive_a: assert property (disable iff (1'b0) !rst_n |=> vdrive == IDLE_DRIVE)
        else $error("vertical levels wrong in reset");
    // the stop pin reaches the enable through two sync stages
    enable_gate_a: assert property (drive_enable == (op_state == CTS_RUN
        && $past(output_stop_in, 2)))
        else $error("drive enable does not follow state and stop input");
    standby_sync_a: assert property (op_state == CTS_STANDBY |-> !sync_gen_run)
        else $error("sync generator runs in standby");
    quiet_window_a: assert property (quiet_two |-> !integration_window_out)
        else $error("window output active while drive stopped");
    quiet_drive_a: assert property (quiet_two |-> vdrive == IDLE_DRIVE)
        else $error("vertical levels wrong while drive stopped");
    sync_hold_a: assert property ((!sync_gen_run && !config_out.readout_on_sync_pins) [*2]
        |-> !line_sync_out && !vertical_sync_out)
        else $error("sync outputs active with generator stopped");
    sweep_count_a: assert property (pscan_sweeps_per_line == 5'h16)
        else $error("partial scan sweep count wrong");
    state_apply_a: assert property ($changed(op_state) |-> strobe_rise_3ago)
        else $error("state changed away from a strobe rise");
    sum_apply_a: assert property ($changed(sum_ok) |-> strobe_rise_3ago)
        else $error("sum flag changed away from a strobe rise");
endmodule

// ### verilog/cts_defines.svh
`ifndef CTS_DEFINES_SVH
`define CTS_DEFINES_SVH
// frame layout
`define CTS_FRAME_BITS      40
`define CTS_SELECT_VALUE    8'h81
`define CTS_CAT_MODE        3'h0
`define CTS_CAT_SHUTTER     3'h2
`define CTS_CAT_PHASE       3'h3
`define CTS_CAT_SYSTEM      3'h4
`define CTS_WORD_RESET      21'h00_0000
// synchroniser reset: strobe, clock and stop pins at their idle high level
`define CTS_SYNC_IDLE       7'h64
// field positions inside a 21-bit word (word bit 0 is frame bit 11)
`define CTS_MODE_PSCAN      3
`define CTS_MODE_STATE_LO   6
`define CTS_MODE_EXPDIS     8
`define CTS_MODE_TRIPLE     9
`define CTS_MODE_SLOW_LO    13
`define CTS_SYS_SYNCDIS     0
`define CTS_SYS_ONSYNC      1
`define CTS_SYS_TAG_LO      2
`define CTS_SYS_SUPPRESS    4
`define CTS_SYS_CHECK       5
`define CTS_SYS_STATUS      6
`define CTS_SYS_FAST        7
`define CTS_SYS_PROG        8
`define CTS_SYS_WIN_LO      10
`define CTS_SYS_INVERT      16
// partial scan fixed sweep
`define CTS_PSCAN_LINES     6'h24
`define CTS_PSCAN_SWEEPS    5'h16
// parallel preset slow shutter counts
`define CTS_PRESET_LONG     5'h01
`define CTS_PRESET_SHORT    5'h00
`endif

// ### verilog/cts_pkg.sv
package cts_pkg;
    typedef enum logic [1:0]
    {
        CTS_RUN     = 2'b00,
        CTS_SLEEP   = 2'b01,
        CTS_STANDBY = 2'b10
    } cts_state_t;

    // vertical phase drive level
    typedef enum logic [1:0]
    {
        CTS_LVL_LOW  = 2'b00,
        CTS_LVL_MID  = 2'b01,
        CTS_LVL_HIGH = 2'b10
    } cts_level_t;

    typedef struct packed
    {
        cts_level_t phase1;
        cts_level_t phase2a;
        cts_level_t phase2b;
        cts_level_t phase3;
        cts_level_t sweep;
    } cts_vdrive_t;

    typedef struct packed
    {
        logic fast_hclk_select;
        logic triple_divide_select;
        logic fast_readout_mode;
        logic partial_scan_mode;
        logic readout_clock_suppress;
        logic vclock_invert;
        logic readout_on_sync_pins;
        logic [1:0] tag_pin_select;
        logic [5:0] sweep_window_length;
        logic [9:0] fast_shutter_count;
        logic [4:0] slow_shutter_count;
    } cts_config_t;
endpackage

// ### verilog/cts_serial_control.sv
`include "cts_defines.svh"

// Overview of operation
// - frame is 40 bits: select byte, category, 21 data bits, checksum byte
// - frame taken only when select byte is 0x81 and, with the system check bit set, checksum passes
// - category picks mode, shutter or system word; phase words and others ignored
// - checksum passes when all five bytes sum to zero modulo 256
// - system check bit clear lets frames land on any checksum; checksum result still reflects the sum
// - operation state taken at strobe rise: run, sleep, standby
// - sleep, standby, reset force drive outputs low and vertical levels fixed
// - output stop low forces sleep; standby wins over it
// - reset clears every control word and forces reset pin states
// - exposure disable holds window low unless status select is on, latched at readout pulse a rise
// - triple divide bit picks by-three pixel clock scheme
// - slow shutter count skips that many vertical periods; ignored in partial scan
// - partial scan sweeps 22 lines per line for 36 lines then window
// - shutter word bits 0 to 9 give sweep pulse count
// - sync generator disable holds sync outputs low
// - readout on sync pins routes readout pulses to sync outputs
// - readout clock suppress stops readout pulses on vertical phases
// - status select shows checksum result on window pin
// - vclock invert flips vertical phases between low and mid
// - parallel mode takes fast clock, readout method and preset from pins
// - fields apply at strobe rise, readout rise or line sync edges
// - serial data sampled on rising serial clock edge
module cts_serial_control
    import cts_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        serial_strobe,
    input  wire logic        serial_clock_in,
    input  wire logic        serial_data_in,
    input  wire logic        input_method_select,
    input  wire logic        output_stop_in,
    input  wire logic        line_sync_in,
    input  wire logic        readout_pulse_a,
    input  wire logic        readout_pulse_b,
    input  wire logic        int_line_sync,
    input  wire logic        int_vertical_sync,
    input  wire logic        exposure_pulse,
    input  wire logic        vclk_phase1,
    input  wire logic        vclk_phase2a,
    input  wire logic        vclk_phase2b,
    input  wire logic        vclk_phase3,
    input  wire logic        sweep_pulse,
    output cts_state_t       op_state,
    output logic             drive_enable,
    output logic             sync_gen_run,
    output logic             line_sync_out,
    output logic             vertical_sync_out,
    output logic             integration_window_out,
    output cts_vdrive_t      vdrive,
    output cts_config_t      config_out,
    output logic             sum_ok,
    output logic             readout_allowed,
    output logic             pscan_sweep_active,
    output logic [4:0]       pscan_sweeps_per_line
);
    // two-stage synchronisers for the serial, select, stop, line sync and readout a pin inputs
    logic [6:0] sync1_reg;
    logic [6:0] sync2_reg;
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            // idle levels, so no false strobe edge or stop request follows reset
            sync1_reg <= `CTS_SYNC_IDLE;
            sync2_reg <= `CTS_SYNC_IDLE;
        end
        else
        begin
            sync1_reg <= {serial_strobe, serial_clock_in, serial_data_in,
                          input_method_select, output_stop_in, line_sync_in, readout_pulse_a};
            sync2_reg <= sync1_reg;
        end
    end
    logic strobe_s, sclk_s, sdata_s, psel_s, stop_s, hsync_s, rda_s;
    assign {strobe_s, sclk_s, sdata_s, psel_s, stop_s, hsync_s, rda_s} = sync2_reg;

    // edge history on synchronised levels
    logic strobe_d_reg, sclk_d_reg, hsync_d_reg, rda_d_reg;
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            strobe_d_reg <= 1'b1;
            sclk_d_reg   <= 1'b1;
            hsync_d_reg  <= 1'b0;
            rda_d_reg    <= 1'b0;
        end
        else
        begin
            strobe_d_reg <= strobe_s;
            sclk_d_reg   <= sclk_s;
            hsync_d_reg  <= hsync_s;
            rda_d_reg    <= rda_s;
        end
    end
    logic strobe_rise, sclk_rise, hsync_fall, rda_rise;
    assign strobe_rise = strobe_s & ~strobe_d_reg;
    assign sclk_rise   = sclk_s & ~sclk_d_reg;
    assign hsync_fall  = ~hsync_s & hsync_d_reg;
    assign rda_rise    = rda_s & ~rda_d_reg;

    // shift register: lsb first, newest bit enters at the top
    logic [39:0] shift_reg;
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            shift_reg <= 40'h00_0000_0000;
        else if (!psel_s && !strobe_s && sclk_rise)
            shift_reg <= {sdata_s, shift_reg[39:1]};
    end

    // frame decode
    logic [7:0]  sel_byte;
    logic [2:0]  category_field;
    logic [20:0] frame_word;
    logic [7:0]  byte_sum;
    logic        check_on;
    logic        frame_ok;
    assign sel_byte       = shift_reg[7:0];
    assign category_field = shift_reg[10:8];
    assign frame_word     = shift_reg[31:11];
    assign byte_sum       = shift_reg[7:0] + shift_reg[15:8] + shift_reg[23:16]
                          + shift_reg[31:24] + shift_reg[39:32];
    logic [20:0] system_word_reg;
    assign check_on = system_word_reg[`CTS_SYS_CHECK];
    assign frame_ok = !psel_s && strobe_rise && (sel_byte == `CTS_SELECT_VALUE)
                    && (!check_on || byte_sum == 8'h00);

    // pending words land here at strobe rise, visible fields later
    logic [20:0] mode_word_reg;
    logic [20:0] shutter_word_reg;
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            mode_word_reg    <= `CTS_WORD_RESET;
            shutter_word_reg <= `CTS_WORD_RESET;
            system_word_reg  <= `CTS_WORD_RESET;
        end
        else if (frame_ok)
        begin
            // phase adjust words carry no state here; unknown codes dropped
            unique case (category_field)
                `CTS_CAT_MODE:    mode_word_reg    <= frame_word;
                `CTS_CAT_SHUTTER: shutter_word_reg <= {11'h000, frame_word[9:0]};
                `CTS_CAT_SYSTEM:  system_word_reg  <= frame_word;
                default:          ;
            endcase
        end
    end

    // checksum status, updated on every selected frame
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            sum_ok <= 1'b0;
        else if (!psel_s && strobe_rise && sel_byte == `CTS_SELECT_VALUE)
            sum_ok <= (byte_sum == 8'h00);
    end

    // slow shutter skip counter; skipped periods apply nothing
    logic [4:0] skip_reg;
    logic       pscan_active;
    assign pscan_active = config_out.partial_scan_mode;
    assign readout_allowed = pscan_active || skip_reg == 5'h00;
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            skip_reg <= 5'h00;
        else if (rda_rise)
            skip_reg <= (skip_reg == 5'h00) ? config_out.slow_shutter_count : skip_reg - 5'h01;
    end

    // reflection: before readout at each line fall, shutter after readout
    logic after_rd_reg;
    logic mode_exp_dis_reg;
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            after_rd_reg <= 1'b0;
        else if (rda_rise)
            after_rd_reg <= readout_allowed;
        else if (hsync_fall)
            after_rd_reg <= 1'b0;
    end
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            mode_exp_dis_reg <= 1'b0;
        else if (rda_rise && readout_allowed)
            mode_exp_dis_reg <= mode_word_reg[`CTS_MODE_EXPDIS];
    end
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            config_out <= '0;
        else
        begin
            if (hsync_fall && !after_rd_reg && readout_allowed)
            begin
                config_out.triple_divide_select   <= mode_word_reg[`CTS_MODE_TRIPLE];
                config_out.partial_scan_mode      <= mode_word_reg[`CTS_MODE_PSCAN];
                config_out.slow_shutter_count     <= mode_word_reg[`CTS_MODE_SLOW_LO +: 5];
                config_out.readout_clock_suppress <= system_word_reg[`CTS_SYS_SUPPRESS];
                config_out.vclock_invert          <= system_word_reg[`CTS_SYS_INVERT];
                config_out.readout_on_sync_pins   <= system_word_reg[`CTS_SYS_ONSYNC];
                config_out.tag_pin_select         <= system_word_reg[`CTS_SYS_TAG_LO +: 2];
                config_out.sweep_window_length    <= system_word_reg[`CTS_SYS_WIN_LO +: 6];
                config_out.fast_hclk_select       <= system_word_reg[`CTS_SYS_FAST];
                config_out.fast_readout_mode      <= system_word_reg[`CTS_SYS_PROG];
            end
            if (hsync_fall && after_rd_reg)
                config_out.fast_shutter_count <= shutter_word_reg[9:0];
            // parallel pins override their fields directly
            if (psel_s)
            begin
                config_out.fast_hclk_select   <= strobe_s;
                config_out.fast_readout_mode  <= sclk_s;
                config_out.slow_shutter_count <= sdata_s ? `CTS_PRESET_LONG : `CTS_PRESET_SHORT;
            end
        end
    end

    // partial scan fixed sweep phase after each readout rise
    logic [5:0] pscan_line_reg;
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            pscan_line_reg <= 6'h00;
        else if (!pscan_active)
            pscan_line_reg <= 6'h00;
        else if (rda_rise)
            pscan_line_reg <= `CTS_PSCAN_LINES;
        else if (hsync_fall && pscan_line_reg != 6'h00)
            pscan_line_reg <= pscan_line_reg - 6'h01;
    end
    assign pscan_sweep_active    = pscan_line_reg != 6'h00;
    assign pscan_sweeps_per_line = `CTS_PSCAN_SWEEPS;

    // operation state and sync disable act at once from the stored word
    logic sleep_req;
    always_comb
    begin
        op_state = mode_word_reg[`CTS_MODE_STATE_LO + 1] ? CTS_STANDBY
                 : mode_word_reg[`CTS_MODE_STATE_LO] ? CTS_SLEEP : CTS_RUN;
        sleep_req = op_state == CTS_SLEEP || !stop_s;
    end
    assign drive_enable = rst_n && op_state == CTS_RUN && !sleep_req;
    assign sync_gen_run = op_state != CTS_STANDBY && !system_word_reg[`CTS_SYS_SYNCDIS];

    // registered pin outputs
    logic status_mode;
    assign status_mode = system_word_reg[`CTS_SYS_STATUS];
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            line_sync_out          <= 1'b0;
            vertical_sync_out      <= 1'b0;
            integration_window_out <= 1'b0;
        end
        else
        begin
            if (!sync_gen_run)
            begin
                line_sync_out     <= 1'b0;
                vertical_sync_out <= 1'b0;
            end
            else if (config_out.readout_on_sync_pins)
            begin
                line_sync_out     <= readout_pulse_b;
                vertical_sync_out <= readout_pulse_a;
            end
            else
            begin
                line_sync_out     <= int_line_sync;
                vertical_sync_out <= int_vertical_sync;
            end
            if (!drive_enable)
                integration_window_out <= 1'b0;
            else if (status_mode)
                integration_window_out <= sum_ok;
            else
                integration_window_out <= exposure_pulse & ~mode_exp_dis_reg;
        end
    end

    // vertical drive levels: low/mid for phases, high for readout unless inverted, high/low for sweep
    function automatic cts_level_t vlev(input logic v, input logic hi, input logic inv);
        cts_level_t l;
        l = v ? CTS_LVL_MID : CTS_LVL_LOW;
        if (inv)
            l = v ? CTS_LVL_LOW : CTS_LVL_MID;
        else if (hi)
            l = CTS_LVL_HIGH;
        return l;
    endfunction
    logic rd_on;
    assign rd_on = rda_s & ~config_out.readout_clock_suppress;
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            vdrive <= {CTS_LVL_MID, CTS_LVL_HIGH, CTS_LVL_HIGH, CTS_LVL_MID, CTS_LVL_HIGH};
        else if (!drive_enable)
            vdrive <= {CTS_LVL_MID, CTS_LVL_HIGH, CTS_LVL_HIGH, CTS_LVL_MID, CTS_LVL_HIGH};
        else
        begin
            vdrive.phase1  <= vlev(vclk_phase1, 1'b0, config_out.vclock_invert);
            vdrive.phase2a <= vlev(vclk_phase2a, rd_on, config_out.vclock_invert);
            vdrive.phase2b <= vlev(vclk_phase2b, rd_on, config_out.vclock_invert);
            vdrive.phase3  <= vlev(vclk_phase3, rd_on, config_out.vclock_invert);
            vdrive.sweep   <= sweep_pulse ? CTS_LVL_HIGH : CTS_LVL_LOW;
        end
    end
endmodule
